// ---- rtl/smf_pkg.sv ----
// Package of constants and types for the supply monitor flag logic
package smf_pkg;
  // Register map: control word index 0xdf, byte address is four times the index
  localparam logic [7:0] SMF_CTRL_IDX      = 8'hdf;
  localparam logic [9:0] SMF_CTRL_ADDR     = 10'h37c;
  localparam logic [9:0] SMF_IRQ_EN_ADDR   = 10'h380;
  localparam logic [9:0] SMF_IRQ_STAT_ADDR = 10'h384;
  localparam logic [9:0] SMF_IRQ_MASK_ADDR = 10'h388;
  // Control register fields
  localparam int SMF_DIG_OK_BIT   = 7;
  localparam int SMF_ANA_OK_BIT   = 6;
  localparam int SMF_FAIL_BIT     = 5;
  localparam int SMF_DIG_TRIP_LSB = 3;
  localparam int SMF_ANA_TRIP_LSB = 1;
  localparam int SMF_EN_BIT       = 0;
  localparam logic [7:0] SMF_CTRL_RST = 8'hde;
  // Interrupt status bits: 0 flag rise, 1 recovery
  localparam logic [1:0] SMF_STAT_RST = 2'h0;
  localparam logic [1:0] SMF_MASK_RST = 2'h0;
  // Timing
  localparam int SMF_CLK_MHZ      = 100;
  localparam int SMF_HOLD_MS      = 250;
  localparam int SMF_HOLD_CYC     = SMF_HOLD_MS * 1000 * SMF_CLK_MHZ;
  localparam int SMF_GLITCH_NS    = 40;
  localparam int SMF_GLITCH_CYC   = (SMF_GLITCH_NS * SMF_CLK_MHZ + 999) / 1000;
  // Trip code sent to the analog comparators
  typedef struct packed {
    logic [1:0] dig_trip;
    logic [1:0] ana_trip;
    logic       enable;
  } smf_cmp_cfg_t;
  // Recovery state
  typedef enum logic [2:0] {
    SMF_IDLE = 3'b001,
    SMF_LOW  = 3'b010,
    SMF_HOLD = 3'b100
  } smf_state_t;
endpackage

// ---- rtl/smf_top.sv ----
// Supply monitor flag logic with Avalon-MM register access
`timescale 1ns/1ps
module smf_top
  import smf_pkg::*;
#(
  parameter int HOLD_CYC   = SMF_HOLD_CYC,
  parameter int GLITCH_CYC = SMF_GLITCH_CYC
) (
  input  wire logic         ref_clk,
  input  wire logic         srst,
  input  wire logic [9:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  input  wire logic [3:0]   avs_byteenable,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest,
  output logic [1:0]        avs_response,
  input  wire logic         dig_cmp_in,
  input  wire logic         ana_cmp_in,
  output smf_cmp_cfg_t      cmp_cfg,
  output logic              irq
);

  localparam int CW = $clog2(HOLD_CYC + 1);
  localparam int GW = $clog2(GLITCH_CYC + 1);

  // Synchronisers for comparator pins
  logic [1:0]  dig_sync_r;           // Stage 0 feeds stage 1 only
  logic [1:0]  ana_sync_r;
  logic        digital_supply_ok;    // Synchronised levels
  logic        analog_supply_ok;
  // Register state
  logic        monitor_enable_r;
  logic [1:0]  dig_trip_r;
  logic [1:0]  ana_trip_r;
  logic        supply_fail_flag_r;
  logic        irq_en_r;              // Interrupt enable bit for the flag
  logic [1:0]  stat_r;               // Sticky events
  logic [1:0]  mask_r;
  // Filter and counter
  logic [GW-1:0] glitch_cnt_r;
  logic          low_qual;           // Low condition long enough
  logic [CW-1:0] hold_cnt_r;
  smf_state_t    state_r;
  logic          hold_done;
  logic          any_low;            // Either synchronised level low
  // Bus helpers
  logic        ack_r;
  logic        wr_hit_ctrl;
  logic        clr_req;
  logic        set_req;
  logic        rd_stat;
  logic        fail_rise;
  logic        fail_fall;
  logic        fail_prev_r;

  // Byte lane 0 write of an address
  // Acts on the taking edge, where waitrequest is sampled low, not the first request edge
  function automatic logic wr_at(input logic [9:0] a);
    return avs_write && ack_r && avs_byteenable[0] && avs_address == a;
  endfunction

  // Two-flop synchronisers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dig_sync_r <= 2'h3;
      ana_sync_r <= 2'h3;
    end else begin
      dig_sync_r <= {dig_sync_r[0], dig_cmp_in};
      ana_sync_r <= {ana_sync_r[0], ana_cmp_in};
    end
  end
  assign digital_supply_ok = dig_sync_r[1];
  assign analog_supply_ok  = ana_sync_r[1];
  // Shared low condition for timer and checks
  assign any_low = !(digital_supply_ok && analog_supply_ok);

  // Glitch filter on the low condition
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      glitch_cnt_r <= '0;
    end else if (!monitor_enable_r || (digital_supply_ok && analog_supply_ok)) begin
      glitch_cnt_r <= '0;
    end else if (glitch_cnt_r != GW'(GLITCH_CYC)) begin
      glitch_cnt_r <= glitch_cnt_r + GW'(1);
    end
  end
  assign low_qual = monitor_enable_r && (glitch_cnt_r == GW'(GLITCH_CYC));

  // Recovery state machine
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r    <= SMF_IDLE;
      hold_cnt_r <= '0;
    end else if (!monitor_enable_r) begin
      state_r    <= SMF_IDLE;
      hold_cnt_r <= '0;
    end else begin
      case (state_r)
        // Waiting for low
        SMF_IDLE: begin
          hold_cnt_r <= '0;
          if (low_qual) begin
            state_r <= SMF_LOW;
          end
        end
        // Supply low, wait for both good
        SMF_LOW: begin
          hold_cnt_r <= '0;
          if (digital_supply_ok && analog_supply_ok) begin
            state_r <= SMF_HOLD;
          end
        end
        SMF_HOLD: begin
          if (!(digital_supply_ok && analog_supply_ok)) begin
            state_r    <= SMF_LOW;
            hold_cnt_r <= '0;
          end else if (hold_done) begin
            state_r    <= SMF_IDLE;
            hold_cnt_r <= '0;
          end else begin
            hold_cnt_r <= hold_cnt_r + CW'(1);
          end
        end
        default: begin
          state_r    <= SMF_IDLE;
          hold_cnt_r <= '0;
        end
      endcase
    end
  end
  // Expiry counts only while both good
  // A low in the last cycle must keep the flag set
  assign hold_done = (state_r == SMF_HOLD) && !any_low
                     && (hold_cnt_r == CW'(HOLD_CYC - 1));

  // Software requests on the flag
  assign wr_hit_ctrl = wr_at(SMF_CTRL_ADDR);
  assign set_req = wr_hit_ctrl && avs_writedata[SMF_FAIL_BIT];
  // Clear refused while a supply low
  assign clr_req = wr_hit_ctrl && !avs_writedata[SMF_FAIL_BIT] && digital_supply_ok && analog_supply_ok
                   && !low_qual;

  // Low-supply flag
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      supply_fail_flag_r <= SMF_CTRL_RST[SMF_FAIL_BIT];
    end else if (low_qual || set_req) begin
      supply_fail_flag_r <= 1'b1;
    end else if (hold_done || clr_req) begin
      supply_fail_flag_r <= 1'b0;
    end
  end

  // Control bits written by software
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      monitor_enable_r <= SMF_CTRL_RST[SMF_EN_BIT];
      dig_trip_r       <= SMF_CTRL_RST[SMF_DIG_TRIP_LSB +: 2];
      ana_trip_r       <= SMF_CTRL_RST[SMF_ANA_TRIP_LSB +: 2];
      irq_en_r         <= 1'b0;
    end else begin
      if (wr_hit_ctrl) begin
        monitor_enable_r <= avs_writedata[SMF_EN_BIT];
        dig_trip_r       <= avs_writedata[SMF_DIG_TRIP_LSB +: 2];
        ana_trip_r       <= avs_writedata[SMF_ANA_TRIP_LSB +: 2];
      end
      if (wr_at(SMF_IRQ_EN_ADDR)) begin
        irq_en_r <= avs_writedata[0];
      end
    end
  end

  // Comparator configuration out
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cmp_cfg <= '{dig_trip: SMF_CTRL_RST[SMF_DIG_TRIP_LSB +: 2],
                   ana_trip: SMF_CTRL_RST[SMF_ANA_TRIP_LSB +: 2],
                   enable: SMF_CTRL_RST[SMF_EN_BIT]};
    end else begin
      cmp_cfg.dig_trip <= dig_trip_r;
      cmp_cfg.ana_trip <= ana_trip_r;
      cmp_cfg.enable   <= monitor_enable_r;
    end
  end

  // Sticky event status, cleared by read
  assign fail_rise = supply_fail_flag_r && !fail_prev_r;
  assign fail_fall = !supply_fail_flag_r && fail_prev_r;
  assign rd_stat   = avs_read && !ack_r && avs_address == SMF_IRQ_STAT_ADDR;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fail_prev_r <= 1'b0;
      stat_r      <= SMF_STAT_RST;
      mask_r      <= SMF_MASK_RST;
    end else begin
      fail_prev_r <= supply_fail_flag_r;
      stat_r      <= (rd_stat ? 2'h0 : stat_r) | {fail_fall, fail_rise};
      if (wr_at(SMF_IRQ_MASK_ADDR)) begin
        mask_r <= avs_writedata[1:0];
      end
    end
  end

  // Interrupt output
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= (supply_fail_flag_r && irq_en_r) || |(stat_r & mask_r);
    end
  end

  // Bus answer: one wait cycle, then acknowledge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ack_r           <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
      avs_response    <= 2'h0;
    end else begin
      ack_r           <= (avs_read || avs_write) && !ack_r;
      avs_waitrequest <= !((avs_read || avs_write) && !ack_r);
      avs_response    <= 2'h0;
      if (avs_read && !ack_r) begin
        case (avs_address)
          SMF_CTRL_ADDR: avs_readdata <= {24'h0, digital_supply_ok, analog_supply_ok, supply_fail_flag_r,
                                          dig_trip_r, ana_trip_r, monitor_enable_r};
          SMF_IRQ_EN_ADDR:   avs_readdata <= {31'h0, irq_en_r};
          SMF_IRQ_STAT_ADDR: avs_readdata <= {30'h0, stat_r};
          SMF_IRQ_MASK_ADDR: avs_readdata <= {30'h0, mask_r};
          default: begin
            avs_readdata <= '0;
            avs_response <= 2'h2;
          end
        endcase
      end
    end
  end

  // Assertions
  property p_flag_set;
    @(posedge ref_clk) disable iff (srst) low_qual |=> supply_fail_flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set on low");

  property p_glitch;
    @(posedge ref_clk) disable iff (srst)
      ($rose(supply_fail_flag_r) && !$past(set_req)) |-> $past(!digital_supply_ok || !analog_supply_ok, 2);
  endproperty
  a_glitch: assert property (p_glitch) else $error("flag set without sustained low");

  property p_no_clear_low;
    @(posedge ref_clk) disable iff (srst)
      (supply_fail_flag_r && (!digital_supply_ok || !analog_supply_ok)) |=> supply_fail_flag_r;
  endproperty
  a_no_clear_low: assert property (p_no_clear_low) else $error("flag cleared while supply low");

  property p_hold_clear;
    @(posedge ref_clk) disable iff (srst) hold_done |=> !supply_fail_flag_r && state_r == SMF_IDLE;
  endproperty
  a_hold_clear: assert property (p_hold_clear) else $error("expiry did not clear flag");

  property p_disabled;
    @(posedge ref_clk) disable iff (srst) !monitor_enable_r |=> hold_cnt_r == '0 && !low_qual;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled monitor still active");

  property p_irq;
    @(posedge ref_clk) disable iff (srst)
      (supply_fail_flag_r && irq_en_r) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  property p_irq_off;
    @(posedge ref_clk) disable iff (srst)
      (!irq_en_r && !(|(stat_r & mask_r))) |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq without enable");

  property p_enable_wr;
    @(posedge ref_clk) disable iff (srst) wr_hit_ctrl |=> monitor_enable_r == $past(avs_writedata[0]);
  endproperty
  a_enable_wr: assert property (p_enable_wr) else $error("enable bit not written");

  property p_trip_out;
    @(posedge ref_clk) disable iff (srst) wr_hit_ctrl |=> ##1 cmp_cfg.dig_trip == $past(avs_writedata[4:3], 2);
  endproperty
  a_trip_out: assert property (p_trip_out) else $error("digital trip not driven");

  property p_ack;
    @(posedge ref_clk) disable iff (srst) (avs_read && avs_waitrequest) |-> ##[1:2] !avs_waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer late");

  // Filter needs four low samples before qualifying
  property p_low_persist;
    @(posedge ref_clk) disable iff (srst)
      $rose(low_qual) |-> $past(any_low, 1) && $past(any_low, 2) && $past(any_low, 3) && $past(any_low, 4);
  endproperty
  a_low_persist: assert property (p_low_persist) else $error("low qualified too early");

  property p_hold_restart;
    @(posedge ref_clk) disable iff (srst)
      (monitor_enable_r && state_r == SMF_HOLD && any_low) |=> state_r == SMF_LOW && hold_cnt_r == '0;
  endproperty
  a_hold_restart: assert property (p_hold_restart) else $error("low did not restart good period");

  property p_stat_sticky;
    @(posedge ref_clk) disable iff (srst) (stat_r[0] && !rd_stat) |=> stat_r[0];
  endproperty
  a_stat_sticky: assert property (p_stat_sticky) else $error("status bit lost before read");

  c_low: cover property (@(posedge ref_clk) disable iff (srst) $rose(supply_fail_flag_r));
  c_recover: cover property (@(posedge ref_clk) disable iff (srst) hold_done);
  c_irq: cover property (@(posedge ref_clk) disable iff (srst) $rose(irq));
  c_restart: cover property (@(posedge ref_clk) disable iff (srst) state_r == SMF_HOLD && any_low);
  c_sw_clear: cover property (@(posedge ref_clk) disable iff (srst) clr_req && supply_fail_flag_r);
endmodule

// ---- bench/smf_cmp_model.sv ----
// Behavioural model of the two analog supply comparators
`timescale 1ns/1ps
module smf_cmp_model
  import smf_pkg::*;
(
  input  smf_cmp_cfg_t cfg,
  input  int           dig_mv,
  input  int           ana_mv,
  output logic         dig_ok,
  output logic         ana_ok
);
  // Trip level in millivolts for one selection code
  function automatic int trip_mv(input logic [1:0] code);
    case (code)
      2'h0: return 4630;
      2'h1: return 3080;
      2'h2: return 2930;
      default: return 2630;
    endcase
  endfunction
  assign dig_ok = (dig_mv > trip_mv(cfg.dig_trip));
  assign ana_ok = (ana_mv > trip_mv(cfg.ana_trip));
endmodule

// ---- bench/tb.sv ----
// Self-checking bench for the supply monitor flag logic
`timescale 1ns/1ps
module tb;
  import smf_pkg::*;
  localparam int HOLD = 50;
  logic         ref_clk = 1'b0;
  logic         srst = 1'b1;
  logic [9:0]   avs_address = 10'h0;
  logic         avs_read = 1'b0;
  logic         avs_write = 1'b0;
  logic [31:0]  avs_writedata = 32'h0;
  logic [31:0]  avs_readdata;
  logic         avs_waitrequest;
  logic [1:0]   avs_response;
  logic         dig_cmp_in;
  logic         ana_cmp_in;
  smf_cmp_cfg_t cmp_cfg;
  logic         irq;
  int           dig_v = 5000;
  int           ana_v = 5000;
  int           trip_tab [4] = '{4630, 3080, 2930, 2630};
  int           n_errors = 0;
  int           n_checks = 0;
  int           i;
  logic [7:0]   lfsr_r = 8'h08;
  logic [31:0]  rdata;
  logic [1:0]   rresp;
  // Model state of the control register
  logic         m_flag = 1'b0;
  logic         m_en = 1'b0;
  logic [1:0]   m_dt = 2'h3;
  logic [1:0]   m_at = 2'h3;

  // Free running clock
  always #5 ref_clk = ~ref_clk;

  smf_top #(.HOLD_CYC(HOLD), .GLITCH_CYC(4)) dut_u (.ref_clk(ref_clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .dig_cmp_in(dig_cmp_in), .ana_cmp_in(ana_cmp_in), .cmp_cfg(cmp_cfg), .irq(irq));
  smf_cmp_model cmp_u (.cfg(cmp_cfg), .dig_mv(dig_v), .ana_mv(ana_v), .dig_ok(dig_cmp_in), .ana_ok(ana_cmp_in));

  // Next value of the stimulus shift register
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Expected control word from the model
  function automatic logic [7:0] exp_ctrl();
    return {dig_v > trip_tab[m_dt], ana_v > trip_tab[m_at], m_flag, m_dt, m_at, m_en};
  endfunction
  // Verdict and end of run
  task automatic summarize();
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One comparison
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [9:0] addr, input logic [7:0] wd);
    int k;
    k = 0;
    avs_address <= addr;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, wd};
    do begin
      @(posedge ref_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 100);
    if (k >= 100) begin
      n_errors++;
      summarize();
    end
    rdata = avs_readdata;
    rresp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Let one edge pass before the next request
    @(posedge ref_clk);
  endtask
  // Control write with model update
  task automatic wctl(input logic [7:0] v);
    if (v[5]) m_flag = 1'b1;
    else if (dig_v > trip_tab[m_dt] && ana_v > trip_tab[m_at]) m_flag = 1'b0;
    m_dt = v[4:3];
    m_at = v[2:1];
    m_en = v[0];
    bus(1'b1, SMF_CTRL_ADDR, v);
  endtask
  // Control read compared with the model
  task automatic rctl();
    bus(1'b0, SMF_CTRL_ADDR, 8'h0);
    chk("ctrl", {24'h0, exp_ctrl()}, rdata);
    chk("ctrl_resp", 2'h0, rresp);
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    chk("cfg_rst", 5'h1e, cmp_cfg);
    rctl();
    bus(1'b0, 10'h3fc, 8'h0);
    chk("unmapped_resp", 2'h2, rresp);
    dig_v <= 3000;
    for (i = 0; i < 4; i++) begin
      lfsr_r = lfsr(lfsr_r);
      wctl({3'b001, i[1:0], lfsr_r[1:0], 1'b0});
      @(posedge ref_clk);
      chk("cmp_cfg", {i[1:0], lfsr_r[1:0], 1'b0}, cmp_cfg);
      repeat (4) @(posedge ref_clk);
      rctl();
    end
    dig_v <= 5000;
    repeat (4) @(posedge ref_clk);
    wctl(8'h1f);
    rctl();
    chk("cfg_en", 5'h1f, cmp_cfg);
    bus(1'b0, SMF_IRQ_STAT_ADDR, 8'h0);
    bus(1'b1, SMF_IRQ_MASK_ADDR, 8'h01);
    bus(1'b1, SMF_IRQ_EN_ADDR, 8'h00);
    dig_v <= 2000;
    repeat (2) @(posedge ref_clk);
    dig_v <= 5000;
    repeat (20) @(posedge ref_clk);
    rctl();
    chk("irq_glitch", 1'b0, irq);
    ana_v <= 2000;
    repeat (20) @(posedge ref_clk);
    m_flag = 1'b1;
    rctl();
    chk("irq_masked_stat", 1'b1, irq);
    wctl(8'h1f);
    rctl();
    bus(1'b0, SMF_IRQ_STAT_ADDR, 8'h0);
    chk("stat", 32'h1, rdata);
    repeat (2) @(posedge ref_clk);
    chk("irq_disabled", 1'b0, irq);
    bus(1'b1, SMF_IRQ_EN_ADDR, 8'h01);
    repeat (2) @(posedge ref_clk);
    chk("irq_enabled", 1'b1, irq);
    ana_v <= 5000;
    repeat (30) @(posedge ref_clk);
    rctl();
    repeat (HOLD) @(posedge ref_clk);
    m_flag = 1'b0;
    rctl();
    chk("irq_recovered", 1'b0, irq);
    wctl(8'h1e);
    ana_v <= 2000;
    repeat (30) @(posedge ref_clk);
    rctl();
    chk("irq_off", 1'b0, irq);
    summarize();
  end
endmodule
